// [logic/scer_regs.sv]
// exception state, keyed reset and sleep control registers
// assumes the core issues word accesses, one at a time, on the link
`timescale 1ns/1ps
`default_nettype none
module scer_regs
(
    scer_link_if.dev link // register and exception link to the core
);
    import scer_pkg::*;

    // --------------------------------------------------------------
    // access decode
    // --------------------------------------------------------------
    logic        wr_state;
    logic        wr_reset;
    logic        wr_sleep;
    logic        key_ok;
    logic [31:0] wd;

    assign wd       = link.reg_wdata;
    assign wr_state = link.reg_wr && (link.reg_addr == SCER_OFS_STATE);
    assign wr_sleep = link.reg_wr && (link.reg_addr == SCER_OFS_SLEEP);
    // the whole write is dropped unless the upper halfword holds the key
    assign key_ok   = (wd[31:16] == SCER_KEY_WRITE);
    assign wr_reset = link.reg_wr && (link.reg_addr == SCER_OFS_RESET)
                      && key_ok;

    // --------------------------------------------------------------
    // pending flags
    // --------------------------------------------------------------
    logic nmi_pend_ff;
    logic dsv_pend_ff;
    logic tick_pend_ff;
    logic nxt_nmi_pend;
    logic nxt_dsv_pend;
    logic nxt_tick_pend;

    // a set in the same cycle as a clear wins, so no request is lost
    always_comb
    begin
        nxt_nmi_pend = nmi_pend_ff;
        if (link.nmi_entry)
            nxt_nmi_pend = 1'b0;
        if (wr_state && wd[SCER_NMI_SET_BIT])
            nxt_nmi_pend = 1'b1;

        nxt_dsv_pend = dsv_pend_ff;
        if (link.dsv_entry)
            nxt_dsv_pend = 1'b0;
        if (wr_state && wd[SCER_DSV_CLR_BIT])
            nxt_dsv_pend = 1'b0;
        // software set is the only source of this pending state
        if (wr_state && wd[SCER_DSV_SET_BIT])
            nxt_dsv_pend = 1'b1;

        nxt_tick_pend = tick_pend_ff;
        if (link.tick_entry)
            nxt_tick_pend = 1'b0;
        if (wr_state && wd[SCER_TICK_CLR_BIT])
            nxt_tick_pend = 1'b0;
        if ((wr_state && wd[SCER_TICK_SET_BIT]) || link.tick_event)
            nxt_tick_pend = 1'b1;
    end

    // flags update on the write edge, so the core sees them next cycle
    always_ff @(posedge link.mclk or posedge link.rst)
    begin
        if (link.rst)
        begin
            nmi_pend_ff  <= 1'b0;
            dsv_pend_ff  <= 1'b0;
            tick_pend_ff <= 1'b0;
        end
        else
        begin
            nmi_pend_ff  <= nxt_nmi_pend;
            dsv_pend_ff  <= nxt_dsv_pend;
            tick_pend_ff <= nxt_tick_pend;
        end
    end

    // --------------------------------------------------------------
    // reset request and sleep configuration
    // --------------------------------------------------------------
    logic sysrst_ff;
    logic wake_any_ff;
    logic sleep_ret_ff;

    // reset request is a one-cycle pulse; the bit itself never stores
    always_ff @(posedge link.mclk or posedge link.rst)
    begin
        if (link.rst)
            sysrst_ff <= 1'b0;
        else
            sysrst_ff <= wr_reset && wd[SCER_SYSRST_BIT];
    end

    // only two sleep bits hold state; deep sleep is not implemented
    always_ff @(posedge link.mclk or posedge link.rst)
    begin
        if (link.rst)
        begin
            wake_any_ff  <= 1'b0;
            sleep_ret_ff <= 1'b0;
        end
        else if (wr_sleep)
        begin
            wake_any_ff  <= wd[SCER_WAKE_ANY_BIT];
            sleep_ret_ff <= wd[SCER_SLEEP_RET_BIT];
        end
    end

    // --------------------------------------------------------------
    // wake and sleep requests to the core
    // --------------------------------------------------------------
    logic wake_ff;
    logic sleep_ff;

    // disabled interrupts only wake the core when wake-on-any is set
    always_ff @(posedge link.mclk or posedge link.rst)
    begin
        if (link.rst)
            wake_ff <= 1'b0;
        else
            wake_ff <= link.irq_new_enabled || link.event_in
                       || (wake_any_ff && link.irq_new_any);
    end

    // sleep is asked for in the cycle after the handler return, for one cycle
    always_ff @(posedge link.mclk or posedge link.rst)
    begin
        if (link.rst)
            sleep_ff <= 1'b0;
        else
            sleep_ff <= link.ret_to_thread && sleep_ret_ff;
    end

    // --------------------------------------------------------------
    // read data
    // --------------------------------------------------------------
    // compose the state word; write-only and reserved bits read zero
    function automatic logic [31:0] scer_state_word
    (
        input logic       nmi,
        input logic       dsv,
        input logic       tick,
        input logic       anyp,
        input logic [5:0] hip,
        input logic [5:0] act
    );
        logic [31:0] w;
        w = SCER_RST_WORD;
        w[SCER_NMI_SET_BIT]  = nmi;
        w[SCER_DSV_SET_BIT]  = dsv;
        w[SCER_TICK_SET_BIT] = tick;
        w[SCER_ANY_PEND_BIT] = anyp;
        w[SCER_HIPEND_LSB +: SCER_EXC_W] = hip;
        w[SCER_ACTIVE_LSB +: SCER_EXC_W] = act;
        return w;
    endfunction : scer_state_word

    logic [31:0] nxt_rdata;

    always_comb
    begin
        nxt_rdata = SCER_RST_WORD;
        case (link.reg_addr)
            SCER_OFS_STATE:
                nxt_rdata = scer_state_word(nmi_pend_ff, dsv_pend_ff,
                    tick_pend_ff, link.irq_pending,
                    link.highest_pending_number,
                    link.active_exception_number);
            SCER_OFS_RESET:
            begin
                nxt_rdata[31:16] = SCER_KEY_READ;
                nxt_rdata[SCER_BYTE_ORDER_BIT] = SCER_BYTE_ORDER;
                nxt_rdata[SCER_SYSRST_BIT] = 1'b0;
                nxt_rdata[SCER_DBGCLR_BIT] = 1'b0;
            end
            SCER_OFS_SLEEP:
            begin
                nxt_rdata[SCER_WAKE_ANY_BIT]  = wake_any_ff;
                nxt_rdata[SCER_DEEP_BIT]      = 1'b0;
                nxt_rdata[SCER_SLEEP_RET_BIT] = sleep_ret_ff;
            end
            default:
                nxt_rdata = SCER_RST_WORD;
        endcase
    end

    logic [31:0] rdata_ff;
    logic        ack_ff;

    // every access, mapped or not, is answered one cycle later
    always_ff @(posedge link.mclk or posedge link.rst)
    begin
        if (link.rst)
        begin
            rdata_ff <= SCER_RST_WORD;
            ack_ff   <= 1'b0;
        end
        else
        begin
            ack_ff <= link.reg_wr || link.reg_rd;
            if (link.reg_rd)
                rdata_ff <= nxt_rdata;
        end
    end

    // --------------------------------------------------------------
    // outputs
    // --------------------------------------------------------------
    assign link.reg_rdata            = rdata_ff;
    assign link.reg_ack              = ack_ff;
    assign link.nmi_pending          = nmi_pend_ff;
    assign link.dsv_pending          = dsv_pend_ff;
    assign link.tick_pending         = tick_pend_ff;
    assign link.system_reset_request = sysrst_ff;
    assign link.wake_req             = wake_ff;
    assign link.sleep_req            = sleep_ff;
endmodule : scer_regs
`default_nettype wire

// [shared/scer_pkg.sv]
// constants shared by both ends of the exception control register link
// assumes one 40 MHz processor clock and word-wide register accesses
`default_nettype none
package scer_pkg;
    // --------------------------------------------------------------
    // register offsets inside the system control space
    // --------------------------------------------------------------
    localparam logic [11:0] SCER_OFS_STATE = 12'hD04; // interrupt_control_state
    localparam logic [11:0] SCER_OFS_RESET = 12'hD0C; // keyed_reset_control
    localparam logic [11:0] SCER_OFS_SLEEP = 12'hD10; // sleep_control

    // --------------------------------------------------------------
    // interrupt_control_state fields
    // --------------------------------------------------------------
    localparam int SCER_NMI_SET_BIT   = 31;
    localparam int SCER_DSV_SET_BIT   = 28;
    localparam int SCER_DSV_CLR_BIT   = 27;
    localparam int SCER_TICK_SET_BIT  = 26;
    localparam int SCER_TICK_CLR_BIT  = 25;
    localparam int SCER_ANY_PEND_BIT  = 22;
    localparam int SCER_HIPEND_LSB    = 12;
    localparam int SCER_ACTIVE_LSB    = 0;
    localparam int SCER_EXC_W         = 6;
    localparam logic [5:0] SCER_IRQ_BASE = 6'h10; // first peripheral line

    // --------------------------------------------------------------
    // keyed_reset_control and sleep_control fields
    // --------------------------------------------------------------
    localparam int SCER_KEY_LSB        = 16;
    localparam logic [15:0] SCER_KEY_WRITE = 16'h05FA;
    localparam logic [15:0] SCER_KEY_READ  = 16'hFA05;
    localparam int SCER_BYTE_ORDER_BIT = 15;
    localparam logic SCER_BYTE_ORDER   = 1'b0;   // little-endian
    localparam int SCER_SYSRST_BIT     = 2;
    localparam int SCER_DBGCLR_BIT     = 1;
    localparam int SCER_WAKE_ANY_BIT   = 4;
    localparam int SCER_DEEP_BIT       = 2;
    localparam int SCER_SLEEP_RET_BIT  = 1;

    // --------------------------------------------------------------
    // reset values and timing
    // --------------------------------------------------------------
    localparam logic [31:0] SCER_RST_WORD = 32'h0000_0000;
    localparam int SCER_ACK_CYCLES = 1; // request edge to ack
endpackage : scer_pkg
`default_nettype wire

// [shared/scer_link_if.sv]
// link between the exception control registers and the processor core
// assumes both ends run on the same clock and reset
`timescale 1ns/1ps
`default_nettype none
interface scer_link_if
(
    input wire logic mclk, // processor clock
    input wire logic rst   // asynchronous reset, active high
);
    // register access: strobes, address and write data core to registers, read data and ack back
    logic        reg_wr;
    logic        reg_rd;
    logic [11:0] reg_addr;
    logic [31:0] reg_wdata;
    logic [31:0] reg_rdata;
    logic        reg_ack;
    // exception state, core to registers
    logic        nmi_entry;
    logic        dsv_entry;
    logic        tick_entry;
    logic        tick_event;
    logic [5:0]  active_exception_number;
    logic [5:0]  highest_pending_number;
    logic        irq_pending;
    logic        irq_new_enabled;
    logic        irq_new_any;
    logic        event_in;
    logic        ret_to_thread;
    // pending and power requests, registers to core
    logic        nmi_pending;
    logic        dsv_pending;
    logic        tick_pending;
    logic        system_reset_request;
    logic        wake_req;
    logic        sleep_req;

    modport dev
    (
        input  mclk, rst, reg_wr, reg_rd, reg_addr, reg_wdata,
        input  nmi_entry, dsv_entry, tick_entry, tick_event,
        input  active_exception_number, highest_pending_number,
        input  irq_pending, irq_new_enabled, irq_new_any, event_in,
        input  ret_to_thread,
        output reg_rdata, reg_ack, nmi_pending, dsv_pending,
        output tick_pending, system_reset_request, wake_req, sleep_req
    );
    modport core
    (
        input  mclk, rst, reg_rdata, reg_ack, nmi_pending, dsv_pending,
        input  tick_pending, system_reset_request, wake_req, sleep_req,
        output reg_wr, reg_rd, reg_addr, reg_wdata,
        output nmi_entry, dsv_entry, tick_entry, tick_event,
        output active_exception_number, highest_pending_number,
        output irq_pending, irq_new_enabled, irq_new_any, event_in,
        output ret_to_thread
    );
endinterface : scer_link_if
`default_nettype wire

// [logic/scer_core.sv]
// core-side end of the exception control register link
// assumes the user side holds a command until cmd_ready answers it
`timescale 1ns/1ps
`default_nettype none
module scer_core
(
    scer_link_if.core  link,         // link to the register block
    input  wire logic  cmd_valid,    // register command request
    input  wire logic  cmd_write,    // 1 write, 0 read
    input  wire logic [11:0] cmd_addr,  // register offset
    input  wire logic [31:0] cmd_wdata, // write data
    output logic       cmd_ready,    // command taken, one cycle
    output logic       rsp_valid,    // access answered, one cycle
    output logic [31:0] rsp_data,    // read data
    input  wire logic  exc_nmi_entry,   // nonmaskable handler entry
    input  wire logic  exc_dsv_entry,   // deferred service entry
    input  wire logic  exc_tick_entry,  // tick exception entry
    input  wire logic  exc_tick_event,  // tick timer reached zero
    input  wire logic [5:0] exc_active, // active exception number
    input  wire logic [5:0] exc_hipend, // highest pending number
    input  wire logic  exc_irq_pend,    // some interrupt pending
    input  wire logic  exc_new_en,      // enabled irq became pending
    input  wire logic  exc_new_any,     // any irq became pending
    input  wire logic  exc_event,       // external event
    input  wire logic  exc_ret_thread,  // return to thread mode
    output logic       pend_nmi,     // nonmaskable pending
    output logic       pend_dsv,     // deferred service pending
    output logic       pend_tick,    // tick exception pending
    output logic       sys_reset,    // system reset request pulse
    output logic       wake,         // wake-up pulse
    output logic       sleep         // sleep-on-return pulse
);
    import scer_pkg::*;

    typedef enum logic [1:0]
    {
        SCER_IDLE = 2'b01,
        SCER_WAIT = 2'b10
    } scer_state_t;

    // --------------------------------------------------------------
    // one access in flight at a time
    // --------------------------------------------------------------
    scer_state_t st_ff;
    logic        wr_ff;
    logic        rd_ff;
    logic [11:0] addr_ff;
    logic [31:0] wdata_ff;
    logic        ready_ff;
    logic        rsp_ff;
    logic [31:0] rsp_data_ff;

    // word accesses only: the offset keeps its low bits as given
    always_ff @(posedge link.mclk or posedge link.rst)
    begin
        if (link.rst)
        begin
            st_ff       <= SCER_IDLE;
            wr_ff       <= 1'b0;
            rd_ff       <= 1'b0;
            addr_ff     <= 12'h000;
            wdata_ff    <= 32'h0000_0000;
            ready_ff    <= 1'b0;
            rsp_ff      <= 1'b0;
            rsp_data_ff <= 32'h0000_0000;
        end
        else
        begin
            wr_ff    <= 1'b0;
            rd_ff    <= 1'b0;
            ready_ff <= 1'b0;
            rsp_ff   <= 1'b0;
            case (st_ff)
                SCER_IDLE:
                    if (cmd_valid && !ready_ff)
                    begin
                        wr_ff    <= cmd_write;
                        rd_ff    <= !cmd_write;
                        addr_ff  <= cmd_addr;
                        wdata_ff <= cmd_wdata;
                        ready_ff <= 1'b1;
                        st_ff    <= SCER_WAIT;
                    end
                SCER_WAIT:
                    if (link.reg_ack)
                    begin
                        rsp_ff      <= 1'b1;
                        rsp_data_ff <= link.reg_rdata;
                        st_ff       <= SCER_IDLE;
                    end
                default:
                    st_ff <= SCER_IDLE;
            endcase
        end
    end

    // --------------------------------------------------------------
    // exception state passed through one register stage
    // --------------------------------------------------------------
    logic [20:0] exc_ff;

    // the number reported is passed through as given; the first irq number is not added
    always_ff @(posedge link.mclk or posedge link.rst)
    begin
        if (link.rst)
            exc_ff <= 21'h00_0000;
        else
            exc_ff <= {exc_nmi_entry, exc_dsv_entry, exc_tick_entry,
                       exc_tick_event, exc_active, exc_hipend,
                       exc_irq_pend, exc_new_en, exc_new_any,
                       exc_event, exc_ret_thread};
    end

    logic [5:0] out_ff;

    always_ff @(posedge link.mclk or posedge link.rst)
    begin
        if (link.rst)
            out_ff <= 6'h00;
        else
            out_ff <= {link.nmi_pending, link.dsv_pending,
                       link.tick_pending, link.system_reset_request,
                       link.wake_req, link.sleep_req};
    end

    assign link.reg_wr    = wr_ff;
    assign link.reg_rd    = rd_ff;
    assign link.reg_addr  = addr_ff;
    assign link.reg_wdata = wdata_ff;
    assign {link.nmi_entry, link.dsv_entry, link.tick_entry,
            link.tick_event, link.active_exception_number,
            link.highest_pending_number, link.irq_pending,
            link.irq_new_enabled, link.irq_new_any, link.event_in,
            link.ret_to_thread} = exc_ff;
    assign cmd_ready = ready_ff;
    assign rsp_valid = rsp_ff;
    assign rsp_data  = rsp_data_ff;
    assign {pend_nmi, pend_dsv, pend_tick, sys_reset, wake, sleep} = out_ff;
endmodule : scer_core
`default_nettype wire

// [test/scer_link_monitor.sv]
// assertions on the link between the core end and the register end
// assumes it sits beside the link instance and sees the same clock
`timescale 1ns/1ps
`default_nettype none
module scer_link_monitor
(
    input wire logic        mclk,       // processor clock
    input wire logic        rst,        // async reset, high
    input wire logic        reg_wr,     // write strobe
    input wire logic        reg_rd,     // read strobe
    input wire logic [11:0] reg_addr,   // byte offset
    input wire logic [31:0] reg_wdata,  // write data
    input wire logic [31:0] reg_rdata,  // read data
    input wire logic        reg_ack,    // access answered
    input wire logic        nmi_entry,  // nonmaskable entry
    input wire logic        tick_event, // tick hardware set
    input wire logic [5:0]  active_exception_number, // active number
    input wire logic        irq_new_enabled, // enabled irq pends
    input wire logic        event_in,   // external event
    input wire logic        nmi_pending,  // nonmaskable pending
    input wire logic        dsv_pending,  // deferred pending
    input wire logic        tick_pending, // tick pending
    input wire logic        system_reset_request, // reset pulse
    input wire logic        wake_req    // wake pulse
);
    import scer_pkg::*;
    // ------
    // decoded accesses
    // ------
    wire st_wr = reg_wr && reg_addr == SCER_OFS_STATE;
    wire st_rd = reg_rd && reg_addr == SCER_OFS_STATE;
    wire any_acc = reg_wr || reg_rd;
    wire key_hit = reg_wr && reg_addr == SCER_OFS_RESET
                   && reg_wdata[31:16] == SCER_KEY_WRITE && reg_wdata[2];

    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    // set beats clear, so each clear is checked only without its set
    ack_match_a : assert property (reg_ack == $past(any_acc))
        else $error("ack does not follow access");
    nmi_set_a : assert property (st_wr && reg_wdata[31] |=> nmi_pending)
        else $error("nonmaskable not pending after set");
    nmi_clear_a : assert property (nmi_entry && !(st_wr && reg_wdata[31])
        |=> !nmi_pending) else $error("entry left nonmaskable pending");
    dsv_hold_a : assert property (!dsv_pending && !(st_wr && reg_wdata[28])
        |=> !dsv_pending) else $error("deferred pending without set");
    dsv_clear_a : assert property (st_wr && reg_wdata[27] && !reg_wdata[28]
        |=> !dsv_pending) else $error("deferred clear ignored");
    tick_set_a : assert property ((st_wr && reg_wdata[26]) || tick_event
        |=> tick_pending) else $error("tick not pending after set");
    tick_clear_a : assert property (st_wr && reg_wdata[25] && !reg_wdata[26]
        && !tick_event |=> !tick_pending) else $error("tick clear ignored");
    reset_key_a : assert property (system_reset_request == $past(key_hit))
        else $error("reset request without keyed write");
    active_read_a : assert property (st_rd |=> reg_rdata[11:0] ==
        {6'h00, $past(active_exception_number)} && reg_rdata[30:29] == 2'h0)
        else $error("active number misread");
    wake_pend_a : assert property (irq_new_enabled || event_in |=> wake_req)
        else $error("no wake after enabled pend");
endmodule : scer_link_monitor
`default_nettype wire

// [test/system_control_exception_regs_test.sv]
// self-checking bench: user commands through the core end to the regs
// assumes both ends share one 40 MHz clock and the link interface
`timescale 1ns/1ps
`default_nettype none
module system_control_exception_regs_test;
    import scer_pkg::*;
    logic        mclk = 1'b0;
    logic        rst = 1'b1;
    logic        cmd_valid = 1'b0;
    logic        cmd_write = 1'b0;
    logic [11:0] cmd_addr = 12'h000;
    logic [31:0] cmd_wdata = 32'h0000_0000;
    logic [7:0]  pl = 8'h00;      // exception input pulses
    logic [5:0]  act = 6'h00;
    logic [5:0]  hip = 6'h00;
    logic        irqp = 1'b0;
    logic        cmd_ready, rsp_valid, pnd_nmi, sleep, wake, sys_reset;
    logic        pnd_dsv, pnd_tick;
    logic [31:0] rsp_data, q, s;
    logic [31:0] errors = 0, checked = 0, n_rst = 0, n_wk = 0, n_slp = 0;

    always #12.5 mclk = ~mclk;
    // pulses are counted so totals can be compared later
    always @(posedge mclk)
    begin
        if (sys_reset === 1'b1) n_rst <= n_rst + 1;
        if (wake === 1'b1) n_wk <= n_wk + 1;
        if (sleep === 1'b1) n_slp <= n_slp + 1;
    end

    scer_link_if link (.mclk(mclk), .rst(rst));
    scer_regs i_scer_regs (.link(link.dev));
    scer_core i_scer_core (.link(link.core), .cmd_valid(cmd_valid),
        .cmd_write(cmd_write), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata),
        .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
        .exc_nmi_entry(pl[0]), .exc_dsv_entry(pl[1]), .exc_tick_entry(pl[2]),
        .exc_tick_event(pl[3]), .exc_new_en(pl[4]), .exc_new_any(pl[5]),
        .exc_event(pl[6]), .exc_ret_thread(pl[7]), .exc_active(act),
        .exc_hipend(hip), .exc_irq_pend(irqp), .pend_nmi(pnd_nmi),
        .pend_dsv(pnd_dsv), .pend_tick(pnd_tick), .sys_reset(sys_reset),
        .wake(wake), .sleep(sleep));
    scer_link_monitor i_scer_link_monitor (.mclk(mclk), .rst(rst),
        .reg_wr(link.reg_wr), .reg_rd(link.reg_rd), .reg_addr(link.reg_addr),
        .reg_wdata(link.reg_wdata), .reg_rdata(link.reg_rdata),
        .reg_ack(link.reg_ack), .nmi_entry(link.nmi_entry),
        .tick_event(link.tick_event),
        .active_exception_number(link.active_exception_number),
        .irq_new_enabled(link.irq_new_enabled), .event_in(link.event_in),
        .nmi_pending(link.nmi_pending), .dsv_pending(link.dsv_pending),
        .tick_pending(link.tick_pending),
        .system_reset_request(link.system_reset_request),
        .wake_req(link.wake_req));

    // ------
    // access tasks
    // ------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            errors++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    // one command, held until taken; the tail lets pulses land
    task automatic xfer(input logic w, input logic [11:0] a,
                        input logic [31:0] d);
        int n;
        cmd_write = w;
        cmd_addr = a;
        cmd_wdata = d;
        cmd_valid = 1'b1;
        n = 0;
        do @(negedge mclk); while (cmd_ready !== 1'b1 && n++ < 20);
        cmd_valid = 1'b0;
        while (rsp_valid !== 1'b1 && n++ < 20) @(negedge mclk);
        chk(32'(n < 20), 32'h0000_0001);
        q = rsp_data;
        repeat (2) @(negedge mclk);
    endtask : xfer

    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        xfer(1'b0, a, 32'h0000_0000);
        chk(q, e);
    endtask : rd

    task automatic pulse(input int i);
        pl[i] = 1'b1;
        @(negedge mclk);
        pl[i] = 1'b0;
        repeat (4) @(negedge mclk);
    endtask : pulse

    task automatic stop_test;
        $display("checked %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : stop_test

    // watchdog: the sequence needs well under a thousand cycles
    initial
    begin
        #(25 * 5000);
        errors++;
        stop_test;
    end

    // set and clear are never written together in one word
    initial
    begin
        repeat (6) @(negedge mclk);
        rst = 1'b0;
        rd(SCER_OFS_STATE, 32'h0000_0000);
        rd(SCER_OFS_RESET, 32'hFA05_0000);
        rd(SCER_OFS_SLEEP, 32'h0000_0000);
        rd(12'hD08, 32'h0000_0000);
        xfer(1'b1, SCER_OFS_STATE, 32'h8000_0000);
        chk({31'h0, pnd_nmi}, 32'h0000_0001);
        xfer(1'b1, SCER_OFS_STATE, 32'h0000_0000);
        rd(SCER_OFS_STATE, 32'h8000_0000);
        pulse(0);
        rd(SCER_OFS_STATE, 32'h0000_0000);
        for (int k = 0; k < 2; k++)
        begin
            s = (k == 0) ? 32'h1000_0000 : 32'h0400_0000;
            xfer(1'b1, SCER_OFS_STATE, s);
            rd(SCER_OFS_STATE, s);
            chk({30'h0, pnd_dsv, pnd_tick}, {30'h0, s[28], s[26]});
            xfer(1'b1, SCER_OFS_STATE, 32'h0000_0000);
            rd(SCER_OFS_STATE, s);
            xfer(1'b1, SCER_OFS_STATE, s >> 1);
            rd(SCER_OFS_STATE, 32'h0000_0000);
            chk({30'h0, pnd_dsv, pnd_tick}, 32'h0000_0000);
        end
        pulse(3);
        rd(SCER_OFS_STATE, 32'h0400_0000);
        pulse(2);
        rd(SCER_OFS_STATE, 32'h0000_0000);
        // number 0x13 is peripheral line 3 once 16 is taken off
        act = 6'h13;
        hip = 6'h2A;
        irqp = 1'b1;
        repeat (4) @(negedge mclk);
        rd(SCER_OFS_STATE, 32'h0042_A013);
        // bit 1 is always written as zero here
        xfer(1'b1, SCER_OFS_RESET, 32'hFA05_0004);
        chk(n_rst, 32'h0000_0000);
        xfer(1'b1, SCER_OFS_RESET, 32'h05FA_8004);
        chk(n_rst, 32'h0000_0001);
        rd(SCER_OFS_RESET, 32'hFA05_0000);
        xfer(1'b1, SCER_OFS_SLEEP, 32'hFFFF_FFFF);
        rd(SCER_OFS_SLEEP, 32'h0000_0012);
        pulse(7);
        chk(n_slp, 32'h0000_0001);
        pulse(5);
        chk(n_wk, 32'h0000_0001);
        xfer(1'b1, SCER_OFS_SLEEP, 32'h0000_0000);
        pulse(7);
        pulse(5);
        chk(n_slp, 32'h0000_0001);
        chk(n_wk, 32'h0000_0001);
        pulse(4);
        pulse(6);
        chk(n_wk, 32'h0000_0003);
        stop_test;
    end
endmodule : system_control_exception_regs_test
`default_nettype wire
